// ### rtl/fct_top.sv
// Fault-count and trip control for a three-phase line sectionalizer.
// Assumes current samples synchronous to pclk and a switch-open contact input.
`timescale 1ns/1ps
module fct_top
    import fct_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES // Shorten in simulation
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensed currents and switch position
    input wire fct_sense_s sense,
    input wire logic sw_open,
    // Trip solenoid drive and interrupt
    output logic trip_sol,
    output logic irq
);

    // Whole state of the block
    typedef struct packed {
        fct_cfg_s cfg; // Settings
        logic [IRQ_W-1:0] irq_stat; // Sticky events
        logic [IRQ_W-1:0] irq_en; // Interrupt enables
        logic [1:0] cnt; // Stored count pulses
        logic trip; // Trip solenoid drive
        logic oc_latch; // Overcurrent seen, awaiting outcome
        logic inrush_armed; // Next restore is treated as inrush
        logic flow_prev; // Flow detect last cycle
        logic open_prev; // Switch position last cycle
        logic [9:0] ops; // Opening operations, 0..999
        logic [TICK_W-1:0] tick_cnt; // Millisecond prescaler
        logic [31:0] rdata; // Read data for the access phase
        logic rerr; // Error for the access phase
    } fct_state_s;

    fct_state_s st_reg;
    fct_state_s st_next;

    // Timer hookups
    logic tick;
    logic rst_busy;
    logic ph_busy;
    logic gd_busy;
    logic rst_load;
    logic inr_load;
    logic [TMR_W-1:0] rst_ms;
    logic [TMR_W-1:0] ph_ms;
    logic [TMR_W-1:0] gd_ms;

    // Current detection terms
    logic flowing;
    logic restrained;
    logic [CUR_W-1:0] ph_base;
    logic [CUR_W-1:0] ph_eff;
    logic ph_block;
    logic gd_block;
    logic ph_oc;
    logic gd_oc;
    logic oc_now;
    logic count_pulse;
    logic cnt_clear;
    logic [1:0] cto;
    logic ph_win; // Phase restraint window, restore edge included
    logic gd_win; // Ground block window, restore edge included

    // Bus decode
    logic setup;
    logic wr_en;
    logic mapped;

    // Largest phase sample
    function automatic logic [CUR_W-1:0] max3(input fct_sense_s s);
        logic [CUR_W-1:0] m;
        m = (s.ph_a > s.ph_b) ? s.ph_a : s.ph_b;
        max3 = (m > s.ph_c) ? m : s.ph_c;
    endfunction : max3

    // Count-reset time in milliseconds
    // Codes 6 and 7 fall back to the longest time
    function automatic logic [TMR_W-1:0] reset_ms(input logic [2:0] sel);
        unique case (sel)
            3'h0: reset_ms = 18'h0_3a98; // 15 s
            3'h1: reset_ms = 18'h0_7530; // 30 s
            3'h2: reset_ms = 18'h0_ea60; // 60 s
            3'h3: reset_ms = 18'h1_5f90; // 90 s
            3'h4: reset_ms = 18'h1_d4c0; // 120 s
            default: reset_ms = 18'h2_bf20; // 180 s
        endcase
    endfunction : reset_ms

    // Phase restraint time, line cycles rounded up to whole ms
    // Rounding up keeps restraint never shorter than set
    function automatic logic [TMR_W-1:0] ph_inr_ms(input logic [1:0] sel);
        int cyc;
        cyc = (int'(sel) + 1) * 5;
        ph_inr_ms = TMR_W'((cyc * 1000 + LINE_HZ - 1) / LINE_HZ);
    endfunction : ph_inr_ms

    // Ground block time in milliseconds
    // Codes 5 to 7 fall back to 5 s
    function automatic logic [TMR_W-1:0] gd_inr_ms(input logic [2:0] sel);
        unique case (sel)
            3'h0: gd_inr_ms = 18'h0_012c; // 0.3 s
            3'h1: gd_inr_ms = 18'h0_02bc; // 0.7 s
            3'h2: gd_inr_ms = 18'h0_05dc; // 1.5 s
            3'h3: gd_inr_ms = 18'h0_0bb8; // 3 s
            default: gd_inr_ms = 18'h0_1388; // 5 s
        endcase
    endfunction : gd_inr_ms

    // Raised phase level; saturates rather than wrapping
    // x6 built as x4 plus x2, no multiplier needed
    function automatic logic [CUR_W-1:0] scale(input logic [CUR_W-1:0] b, input logic [2:0] sel);
        logic [CUR_W+3:0] p;
        unique case (sel)
            3'h1: p = {4'h0, b} << 1;
            3'h2: p = {4'h0, b} << 2;
            3'h3: p = ({4'h0, b} << 2) + ({4'h0, b} << 1);
            3'h4: p = {4'h0, b} << 3;
            default: p = {4'h0, b};
        endcase
        scale = (p[CUR_W+3:CUR_W] != 4'h0) ? '1 : p[CUR_W-1:0];
    endfunction : scale

    // Timer load values follow the live settings
    assign rst_ms = reset_ms(st_reg.cfg.reset_sel);
    assign ph_ms = ph_inr_ms(st_reg.cfg.ph_inrush_sel);
    assign gd_ms = gd_inr_ms(st_reg.cfg.gnd_inrush_sel);

    // Millisecond strobe from the prescaler
    // Shared by all timers so their ticks stay in step
    assign tick = (st_reg.tick_cnt == TICK_W'(TICK_CYCLES_P - 1));

    // Flow and restraint detection on the phases
    assign flowing = (max3(sense) >= ZERO_HA);
    assign restrained = (max3(sense) >= RESTRAIN_HA);

    // Restraint windows. The timers turn busy one edge after the restore,
    // so the restore edge is added here; without it the first inrush
    // sample would be judged against the normal levels.
    assign ph_win = ph_busy || inr_load;
    assign gd_win = gd_busy || inr_load;

    // Phase level: normal, or raised or blocked while restraint runs
    assign ph_base = ph_thr(st_reg.cfg.ph_sel);
    // Settings beyond x8 block the phase detector outright
    assign ph_block = ph_win && (st_reg.cfg.mult_sel >= MULT_BLOCK_SEL);
    assign ph_eff = ph_win ? scale(ph_base, st_reg.cfg.mult_sel) : ph_base;
    assign ph_oc = !ph_block && (max3(sense) >= ph_eff);

    // Ground level: configured block or inrush block
    // Phase and ground windows run independently
    assign gd_block = (st_reg.cfg.gnd_sel >= GND_BLOCK_SEL) || gd_win;
    assign gd_oc = !gd_block && (sense.gnd >= gnd_thr(st_reg.cfg.gnd_sel));
    assign oc_now = ph_oc || gd_oc;

    // A count only when a latched overcurrent dies to no flow at all
    // Flow under half an ampere counts as interrupted
    assign count_pulse = st_reg.oc_latch && !oc_now && !flowing && !sw_open;

    // Reset timer: held full while interrupted or empty, runs on flow
    // Any gap in flow restarts the whole span
    assign rst_load = !flowing || (st_reg.cnt == 2'h0);
    assign cnt_clear = flowing && !rst_busy && (st_reg.cnt != 2'h0);

    // Restraint starts when flow returns after a clean interruption
    assign inr_load = flowing && !st_reg.flow_prev && st_reg.inrush_armed;

    // Code 0 behaves as one count
    // A dead setting becomes the safest one, never zero counts
    assign cto = (st_reg.cfg.counts_to_open == 2'h0) ? 2'h1 : st_reg.cfg.counts_to_open;

    // APB phases; zero wait states
    // Reads return the state seen in the setup cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign mapped = (paddr == CFG_OFS) || (paddr == STAT_OFS) || (paddr == IRQ_STAT_OFS) ||
        (paddr == IRQ_CLR_OFS) || (paddr == IRQ_EN_OFS) || (paddr == OPS_OFS);

    // Next-state logic for the whole block
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        logic [1:0] cnt_n;
        ev = '0;
        clr = '0;
        st_next = st_reg;
        cnt_n = st_reg.cnt;

        // Prescaler wraps every millisecond
        st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 1'b1;
        st_next.flow_prev = flowing;
        st_next.open_prev = sw_open;

        // Overcurrent bookkeeping while the switch is closed
        // Restraint drops the latch so a downline clear is not counted
        if (oc_now && !sw_open) begin
            st_next.oc_latch = 1'b1;
        end else if (st_reg.oc_latch) begin
            if (restrained) begin
                st_next.oc_latch = 1'b0;
            end else if (!flowing) begin
                st_next.oc_latch = 1'b0;
            end
        end

        // Interruption decides how the next restore is treated
        // Judged at the fall of flow, before the latch is dropped
        if (st_reg.flow_prev && !flowing) begin
            st_next.inrush_armed = !(st_reg.oc_latch || oc_now);
        end else if (inr_load) begin
            st_next.inrush_armed = 1'b0;
        end

        // Pulse counter saturates at three
        // A fourth pulse is lost; only three can be stored
        if (count_pulse && cnt_n != 2'h3) begin
            cnt_n = cnt_n + 2'h1;
        end
        if (count_pulse) begin
            ev[IRQ_COUNT] = 1'b1;
        end
        // Timed erase of stored pulses
        if (cnt_clear) begin
            cnt_n = 2'h0;
            ev[IRQ_RESET] = 1'b1;
        end

        // Trip once the count reaches the setting
        // Open position overrides counting and trip
        if (sw_open) begin
            cnt_n = 2'h0;
            st_next.trip = 1'b0;
            st_next.oc_latch = 1'b0;
        end else if (cnt_n >= cto) begin
            st_next.trip = 1'b1;
            if (!st_reg.trip) begin
                ev[IRQ_TRIP] = 1'b1;
            end
        end
        st_next.cnt = cnt_n;

        // Opening operations counter, three digits
        // Counted on the change to open, not while open
        if (sw_open && !st_reg.open_prev) begin
            st_next.ops = (st_reg.ops == OPS_MAX) ? 10'h000 : st_reg.ops + 10'h001;
            ev[IRQ_OPEN] = 1'b1;
        end

        // Register writes take effect in the access phase
        // Reserved configuration bits are forced to zero
        if (wr_en) begin
            unique case (paddr)
                CFG_OFS: st_next.cfg = fct_cfg_s'({11'h000, pwdata[20:0]});
                IRQ_CLR_OFS: clr = pwdata[IRQ_W-1:0];
                IRQ_EN_OFS: st_next.irq_en = pwdata[IRQ_W-1:0];
                default: ; // Read-only or unmapped
            endcase
        end
        // New events win over a clear in the same cycle
        st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;

        // Read data captured in the setup phase
        if (setup) begin
            st_next.rerr = !mapped;
            unique case (paddr)
                CFG_OFS: st_next.rdata = 32'(st_reg.cfg);
                STAT_OFS: st_next.rdata = {23'h00_0000, sw_open, st_reg.inrush_armed, gd_busy,
                    ph_busy, st_reg.oc_latch, flowing, st_reg.trip, st_reg.cnt};
                IRQ_STAT_OFS: st_next.rdata = {28'h000_0000, st_reg.irq_stat};
                IRQ_EN_OFS: st_next.rdata = {28'h000_0000, st_reg.irq_en};
                OPS_OFS: st_next.rdata = {22'h00_0000, st_reg.ops};
                default: st_next.rdata = 32'h0000_0000; // Clear register and holes
            endcase
        end
    end

    // State register; constants only under reset
    // Reset leaves ground blocked and three counts to open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{cfg: CFG_RESET, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Count-reset interval
    fct_timer u_rst_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .load(rst_load),
        .run(flowing),
        .load_val(rst_ms),
        .busy(rst_busy)
    );

    // Phase inrush restraint interval
    // Runs regardless of flow once started
    fct_timer u_ph_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .load(inr_load),
        .run(1'b1),
        .load_val(ph_ms),
        .busy(ph_busy)
    );

    // Ground inrush block interval
    // Loaded on the same restore edge as the phase timer
    fct_timer u_gd_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .load(inr_load),
        .run(1'b1),
        .load_val(gd_ms),
        .busy(gd_busy)
    );

    // Outputs
    // Error shown only in the access phase
    // Level interrupt, high until cleared or masked
    assign prdata = st_reg.rdata;
    assign pslverr = st_reg.rerr && psel && penable;
    assign pready = 1'b1; // Every access completes without wait
    assign trip_sol = st_reg.trip;
    assign irq = |(st_reg.irq_stat & st_reg.irq_en);

endmodule : fct_top

// ### rtl/fct_pkg.sv
// Package for the sectionalizer fault-count and trip control block.
// Assumes a 125 MHz pclk, APB register access and current samples in half-amperes.
package fct_pkg;

    // Clock and timebase
    localparam int CLK_NS = 8; // pclk period
    localparam int TICK_NS = 1_000_000; // One millisecond timebase
    localparam int TICK_CYCLES = TICK_NS / CLK_NS; // Cycles per millisecond tick
    localparam int TICK_W = 17; // Width of the tick prescaler
    localparam int TMR_W = 18; // Millisecond timer width, holds 180000
    localparam int LINE_HZ = 60; // Base frequency for inrush cycles

    // Current levels, half-ampere units
    localparam int CUR_W = 16;
    localparam logic [CUR_W-1:0] RESTRAIN_HA = 16'h000a; // 5 A load restraint
    localparam logic [CUR_W-1:0] ZERO_HA = 16'h0001; // Below this counts as no flow

    // Register byte offsets
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFS = 8'h10;
    localparam logic [7:0] OPS_OFS = 8'h14;

    // Selector codes with special meaning
    localparam logic [3:0] GND_BLOCK_SEL = 4'hc;
    localparam logic [2:0] MULT_BLOCK_SEL = 3'h5;
    localparam logic [9:0] OPS_MAX = 10'h3e7; // 999, counter wraps after it
    localparam int IRQ_W = 4;

    // Configuration register layout
    typedef struct packed {
        logic [10:0] rsvd; // [31:21] read as zero
        logic [2:0] gnd_inrush_sel; // [20:18]
        logic [1:0] ph_inrush_sel; // [17:16]
        logic [2:0] mult_sel; // [15:13]
        logic [2:0] reset_sel; // [12:10]
        logic [1:0] counts_to_open; // [9:8]
        logic [3:0] gnd_sel; // [7:4]
        logic [3:0] ph_sel; // [3:0]
    } fct_cfg_s;

    localparam fct_cfg_s CFG_RESET = '{rsvd: 11'h000, gnd_inrush_sel: 3'h0, ph_inrush_sel: 2'h0,
        mult_sel: 3'h0, reset_sel: 3'h0, counts_to_open: 2'h3, gnd_sel: GND_BLOCK_SEL, ph_sel: 4'h0};

    // Sensed currents from the transformer front end
    typedef struct packed {
        logic [CUR_W-1:0] ph_a;
        logic [CUR_W-1:0] ph_b;
        logic [CUR_W-1:0] ph_c;
        logic [CUR_W-1:0] gnd;
    } fct_sense_s;

    // Interrupt event bits
    localparam int IRQ_COUNT = 0; // Count pulse registered
    localparam int IRQ_TRIP = 1; // Trip output asserted
    localparam int IRQ_RESET = 2; // Counts erased by reset timer
    localparam int IRQ_OPEN = 3; // Switch reported open

    // Phase minimum-actuating level in half-amperes
    function automatic logic [CUR_W-1:0] ph_thr(input logic [3:0] sel);
        unique case (sel)
            4'h0: ph_thr = 16'h0020;
            4'h1: ph_thr = 16'h0030;
            4'h2: ph_thr = 16'h0050;
            4'h3: ph_thr = 16'h0070;
            4'h4: ph_thr = 16'h00a0;
            4'h5: ph_thr = 16'h00e0;
            4'h6: ph_thr = 16'h0140;
            4'h7: ph_thr = 16'h01c0;
            4'h8: ph_thr = 16'h0200;
            4'h9: ph_thr = 16'h0250;
            4'ha: ph_thr = 16'h0280;
            4'hb: ph_thr = 16'h0380;
            default: ph_thr = 16'h0500; // 640 A, also for unused codes
        endcase
    endfunction : ph_thr

    // Ground minimum-actuating level in half-amperes
    function automatic logic [CUR_W-1:0] gnd_thr(input logic [3:0] sel);
        unique case (sel)
            4'h0: gnd_thr = 16'h0007;
            4'h1: gnd_thr = 16'h000e;
            4'h2: gnd_thr = 16'h0020;
            4'h3: gnd_thr = 16'h0028;
            4'h4: gnd_thr = 16'h0038;
            4'h5: gnd_thr = 16'h0050;
            4'h6: gnd_thr = 16'h0070;
            4'h7: gnd_thr = 16'h00a0;
            4'h8: gnd_thr = 16'h00e0;
            4'h9: gnd_thr = 16'h0140;
            4'ha: gnd_thr = 16'h01c0;
            default: gnd_thr = 16'h0280; // 320 A; codes 12+ are blocked elsewhere
        endcase
    endfunction : gnd_thr

endpackage : fct_pkg

// ### rtl/fct_timer.sv
// Millisecond down-counter used for the reset and inrush intervals.
// Assumes a one-cycle tick strobe from the owning block's prescaler.
`timescale 1ns/1ps
module fct_timer
    import fct_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic tick,
    input wire logic load,
    input wire logic run,
    input wire logic [TMR_W-1:0] load_val,
    // Status
    output logic busy
);

    // Whole state of the timer
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } fct_tmr_s;

    fct_tmr_s st_reg;
    fct_tmr_s st_next;

    // Load has priority so a held load keeps the timer full
    always_comb begin
        st_next = st_reg;
        if (load) begin
            st_next.cnt = load_val;
        end else if (run && tick && st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = (st_reg.cnt != '0);

endmodule : fct_timer

// ### tb/fct_checker.sv
// Checker for fct_top: bus answers and trip solenoid timing.
// Assumes it is bound onto fct_top and sees only its ports.
`timescale 1ns/1ps
module fct_checker
    import fct_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Line side
    input wire fct_sense_s sense,
    input wire logic sw_open,
    input wire logic trip_sol,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase, unmapped place, no phase flow
    wire acc = psel && penable;
    wire bad = paddr[1:0] != 2'h0 || paddr > OPS_OFS;
    wire no_flow = sense.ph_a == 16'h0000 && sense.ph_b == 16'h0000 && sense.ph_c == 16'h0000;

    AST_PREADY: assert property (pready) else $error("pready low");
    AST_ERR_MAP: assert property (acc && bad && !pwrite |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    AST_ERR_OK: assert property (acc && !bad |-> !pslverr) else $error("error on mapped place");
    AST_ERR_IDLE: assert property (!acc |-> !pslverr) else $error("error outside access");
    AST_TRIP_CAUSE: assert property ($rose(trip_sol) |-> $past(no_flow))
        else $error("trip without interruption");
    AST_TRIP_SHUT: assert property ($rose(trip_sol) |-> !$past(sw_open))
        else $error("trip while open");
    AST_TRIP_CLR: assert property (sw_open |=> !trip_sol [*2])
        else $error("trip kept while open");
    AST_TRIP_HOLD: assert property (trip_sol && !sw_open |=> trip_sol)
        else $error("trip dropped early");
    // Main scenarios reached
    cover property ($rose(trip_sol));
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule : fct_checker

bind fct_top fct_checker chk_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .sw_open(sw_open), .trip_sol(trip_sol), .irq(irq));

// ### tb/fct_line_model.sv
// Line model: current sensors, trip solenoid and switch contacts.
// Assumes commanded currents change just after pclk edges.
`timescale 1ns/1ps
module fct_line_model
    import fct_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Commanded currents and solenoid drive
    input wire logic [15:0] ph_cmd,
    input wire logic [15:0] gnd_cmd,
    input wire logic trip_sol,
    // Sensed currents and switch position
    output fct_sense_s sense,
    output logic sw_open
);
    logic [4:0] dly; // Mechanism travel time

    // Open contacts carry no current at all
    assign sense = sw_open ? '0 : fct_sense_s'{ph_a: ph_cmd, ph_b: 16'h0000, ph_c: 16'h0000, gnd: gnd_cmd};

    // Solenoid trips after 16 cycles, reclose 8 cycles later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_open <= 1'b0;
            dly <= 5'h00;
        end else if (!sw_open && trip_sol) begin
            dly <= dly + 5'h01;
            if (dly == 5'h0f) begin
                sw_open <= 1'b1;
                dly <= 5'h00;
            end
        end else if (sw_open) begin
            dly <= dly + 5'h01;
            if (dly == 5'h07) begin // Closed again by the operator
                sw_open <= 1'b0;
                dly <= 5'h00;
            end
        end
    end
endmodule : fct_line_model

// ### tb/fct_top_test.sv
// Testbench for fct_top: APB tasks and fault sequences.
// Assumes fct_line_model stands for the line and the switch.
`timescale 1ns/1ps
module fct_top_test;
    import fct_pkg::*;
    localparam int TK = 2; // Cycles per millisecond, keeps runs short
    // Clock, reset and bus
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, lerr, trip_sol, irq, sw_open;
    logic [15:0] ph = 16'h0000, gn = 16'h0000; // Half-amperes
    fct_sense_s sense;
    int err_total = 0, samples_checked = 0, opens = 0;
    // Minimum-actuating levels in half-amperes
    int pt[13] = '{32, 48, 80, 112, 160, 224, 320, 448, 512, 592, 640, 896, 1280};
    int gt[12] = '{7, 14, 32, 40, 56, 80, 112, 160, 224, 320, 448, 640};

    always #4 pclk = ~pclk;
    always @(posedge sw_open) opens++;

    fct_top #(.TICK_CYCLES_P(TK)) dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense(sense), .sw_open(sw_open), .trip_sol(trip_sol), .irq(irq));
    fct_line_model lm(.pclk(pclk), .presetn(presetn), .ph_cmd(ph), .gnd_cmd(gn), .trip_sol(trip_sol),
        .sense(sense), .sw_open(sw_open));

    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer, entered just after an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        lerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rchk

    function automatic logic [31:0] cfg(input logic [3:0] p, g, input logic [1:0] c, input logic [2:0] m);
        return {16'h0000, m, 3'h0, c, g, p};
    endfunction : cfg

    // Current for hold cycles, then tail level, then none
    task automatic shot(input int p, g, hold, tail);
        ph <= p[15:0]; gn <= g[15:0];
        repeat (hold) @(posedge pclk);
        ph <= tail[15:0]; gn <= 16'h0000;
        repeat (8) @(posedge pclk);
        ph <= 16'h0000;
        repeat (4) @(posedge pclk);
    endtask : shot

    // Trip seen, then switch cycle allowed to finish
    task automatic trip_is(input logic e);
        chk("trip", {31'h0, e}, {31'h0, trip_sol});
        repeat (40) @(posedge pclk);
    endtask : trip_is

    initial begin
        repeat (90000) @(posedge pclk);
        err_total++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk("cfg", CFG_OFS, 32'h0000_03c0);
        xfer(1'b1, STAT_OFS, 32'hffff_ffff);
        rchk("stat", STAT_OFS, 32'h0000_0000);
        rchk("unmapped", 8'h18, 32'h0000_0000);
        chk("slverr", 32'h1, {31'h0, lerr});
        xfer(1'b1, IRQ_EN_OFS, 32'h0000_0001);
        $display("registers done");
        for (int n = 1; n <= 3; n++) begin
            xfer(1'b1, CFG_OFS, cfg(4'h0, GND_BLOCK_SEL, n[1:0], 3'h0));
            for (int k = 1; k < n; k++) shot(32, 0, 3, 0);
            rchk("count", STAT_OFS, n - 1);
            shot(32, 0, 3, 0);
            trip_is(1'b1);
            rchk("cleared", STAT_OFS, 32'h0000_0000);
            if (n == 1) begin
                chk("irq", 32'h1, {31'h0, irq});
                xfer(1'b1, IRQ_EN_OFS, 32'h0000_0000);
                chk("irq_mask", 32'h0, {31'h0, irq});
                xfer(1'b1, IRQ_CLR_OFS, 32'h0000_000f);
                rchk("irq_stat", IRQ_STAT_OFS, 32'h0000_0000);
            end
        end
        rchk("ops", OPS_OFS, 32'h0000_0003);
        xfer(1'b1, CFG_OFS, cfg(4'h0, GND_BLOCK_SEL, 2'h1, 3'h0));
        shot(32, 0, 3, 10);
        trip_is(1'b0);
        $display("counting done");
        for (int i = 0; i < 13; i++) begin
            xfer(1'b1, CFG_OFS, cfg(i[3:0], GND_BLOCK_SEL, 2'h1, 3'h0));
            shot(pt[i] - 1, 0, 3, 0);
            trip_is(1'b0);
            shot(pt[i], 0, 3, 0);
            trip_is(1'b1);
        end
        for (int i = 0; i < 12; i++) begin
            xfer(1'b1, CFG_OFS, cfg(4'hc, i[3:0], 2'h1, 3'h0));
            shot(16, gt[i] - 1, 700, 0);
            trip_is(1'b0);
            if (i == 0) begin
                shot(16, gt[i], 300, 0);
                trip_is(1'b0);
            end
            shot(16, gt[i], 700, 0);
            trip_is(1'b1);
        end
        xfer(1'b1, CFG_OFS, cfg(4'hc, GND_BLOCK_SEL, 2'h1, 3'h0));
        shot(16, 1280, 700, 0);
        trip_is(1'b0);
        $display("thresholds done");
        xfer(1'b1, CFG_OFS, cfg(4'h0, GND_BLOCK_SEL, 2'h2, 3'h0));
        shot(32, 0, 3, 0);
        xfer(1'b1, CFG_OFS, cfg(4'h0, GND_BLOCK_SEL, 2'h2, 3'h1));
        repeat (200) @(posedge pclk);
        shot(63, 0, 100, 0);
        trip_is(1'b1);
        xfer(1'b1, CFG_OFS, cfg(4'h0, GND_BLOCK_SEL, 2'h1, 3'h1));
        shot(16, 0, 5, 0);
        shot(63, 0, 100, 0);
        trip_is(1'b0);
        shot(63, 0, 400, 0);
        trip_is(1'b1);
        xfer(1'b1, CFG_OFS, cfg(4'h0, GND_BLOCK_SEL, 2'h1, MULT_BLOCK_SEL));
        shot(16, 0, 5, 0);
        shot(1280, 0, 100, 0);
        trip_is(1'b0);
        $display("inrush done");
        xfer(1'b1, CFG_OFS, cfg(4'h0, GND_BLOCK_SEL, 2'h2, 3'h0));
        shot(32, 0, 3, 0);
        shot(16, 0, 16000, 0);
        ph <= 16'h0010;
        repeat (16000) @(posedge pclk);
        rchk("count_kept", STAT_OFS, 32'h0000_0009);
        repeat (15000) @(posedge pclk);
        rchk("count_gone", STAT_OFS, 32'h0000_0008);
        rchk("irq_erase", IRQ_STAT_OFS, 32'h0000_000f);
        rchk("ops_all", OPS_OFS, opens);
        $display("reset timer done");
        report_and_stop();
    end
endmodule : fct_top_test
